// File: dv/ipr_regs_bench.sv
// Self-checking bench for the interrupt priority register bank
`timescale 1ns/1ns
module ipr_regs_bench;
	// Unimplemented bits per register, field low bit and register of each source
	localparam logic [15:0] UM [0:5]  = '{16'h8888, 16'h8888, 16'hF888, 16'h8888, 16'h88F8, 16'h8888};
	localparam int          BT [0:21] = '{12, 8, 4, 0, 12, 8, 4, 0, 8, 4, 0, 12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 0};
	localparam int          RG [0:21] = '{0, 0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 5, 5, 5, 5};
	// Bus and request signals
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, q;
	logic [21:0] want, src_req, req_fwd_o;
	logic [2:0]  top_level_o;
	wire  [2:0]  lv [0:21];       // Level outputs by source index, driven by the ports
	logic [15:0] ex [0:5];        // Expected register contents
	int          n_mismatch, samples_checked, cycles;

	ipr_src_model ipr_src_model_inst (.clk_i(clk_i), .rst_i(rst_i), .want_i(want), .req_o(src_req));
	ipr_regs #(.ADDR_WIDTH(8)) ipr_regs_inst (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .src_req_i(src_req),
		.req_fwd_o(req_fwd_o), .top_level_o(top_level_o),
		.timer_two_level_o(lv[0]), .out_compare_two_level_o(lv[1]), .in_capture_two_level_o(lv[2]),
		.dma_ch_zero_level_o(lv[3]), .uart_one_rx_level_o(lv[4]), .spi_one_event_level_o(lv[5]),
		.spi_one_error_level_o(lv[6]), .timer_three_level_o(lv[7]), .dma_ch_one_level_o(lv[8]),
		.adc_one_done_level_o(lv[9]), .uart_one_tx_level_o(lv[10]), .change_notify_level_o(lv[11]),
		.comparator_level_o(lv[12]), .i2c_one_master_level_o(lv[13]),
		.i2c_one_slave_level_o(lv[14]), .in_capture_eight_level_o(lv[15]),
		.in_capture_seven_level_o(lv[16]), .ext_irq_one_level_o(lv[17]),
		.timer_four_level_o(lv[18]), .out_compare_four_level_o(lv[19]),
		.out_compare_three_level_o(lv[20]), .dma_ch_two_level_o(lv[21]));

	// Clock at 25 MHz
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// Level given to each source in the map test; spans codes one to seven
	function automatic logic [2:0] lvl(input int s);
		return 3'((s % 7) + 1);
	endfunction

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	// One classic cycle; held until ack is sampled, bounded so a dead slave cannot hang us
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
		int n;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		chk({31'h0000_0000, ack_o}, 32'h0000_0001, "ack");
	endtask

	// Read and compare one register
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		wb(1'b0, a, 16'h0000, 4'h3);
		chk(q, {16'h0000, e}, "read data");
	endtask

	// Let requests pass the source flop and the forward flop
	task automatic settle();
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	// Reset contents and level outputs
	task automatic t_reset();
		for (int r = 0; r < 6; r++) rd(8'(r * 4), 16'h4444 & ~UM[r]);
		for (int s = 0; s < 22; s++) chk(32'(lv[s]), 32'h0000_0004, "reset level");
		$display("reset test done");
	endtask

	// Distinct levels across the fields of each register, ones aimed at unimplemented bits
	task automatic t_map();
		for (int r = 0; r < 6; r++) ex[r] = 16'h0000;
		for (int s = 0; s < 22; s++) ex[RG[s]] |= 16'(lvl(s)) << BT[s];
		for (int r = 0; r < 6; r++) wb(1'b1, 8'(r * 4), ex[r] | UM[r], 4'h3);
		for (int r = 0; r < 6; r++) rd(8'(r * 4), ex[r]);
		@(negedge clk_i);
		for (int s = 0; s < 22; s++) chk(32'(lv[s]), 32'(lvl(s)), "level");
		$display("map test done");
	endtask

	// Unmapped places are acked, read zero and leave the bank alone
	task automatic t_unmapped();
		wb(1'b1, 8'h18, 16'h0000, 4'h3);
		wb(1'b1, 8'h20, 16'h0000, 4'h3);
		rd(8'h18, 16'h0000);
		rd(8'h20, 16'h0000);
		rd(8'h00, ex[0]);
		$display("unmapped test done");
	endtask

	// Forwarding, top level and disabled sources
	task automatic t_req();
		@(posedge clk_i);
		want <= 22'h3F_FFFF;
		settle();
		chk(32'(req_fwd_o), 32'h003F_FFFF, "forward all");
		chk(32'(top_level_o), 32'h0000_0007, "top seven");
		want <= 22'h20_4081;
		settle();
		chk(32'(top_level_o), 32'h0000_0001, "top one");
		@(posedge clk_i);
		want <= 22'h00_0001;
		settle();
		chk(32'(top_level_o), 32'h0000_0001, "top lone one");
		wb(1'b1, 8'h00, 16'h0000, 4'h1);
		rd(8'h00, ex[0] & 16'hFF00);
		@(posedge clk_i);
		want <= 22'h00_008C;
		settle();
		chk(32'(req_fwd_o), 32'h0000_0080, "disabled dropped");
		chk(32'(top_level_o), 32'h0000_0001, "top without disabled");
		want <= 22'h00_000C;
		settle();
		chk(32'(req_fwd_o), 32'h0000_0000, "nothing forwarded");
		chk(32'(top_level_o), 32'h0000_0000, "top empty");
		$display("request test done");
	endtask

	// Counts and verdict
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Hang guard, far above the hundred or so cycles the tests take
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	// Main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i} = 4'h8;
		adr_i = 8'h00;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		want = 22'h00_0000;
		n_mismatch = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_map();
		t_unmapped();
		t_req();
		print_verdict();
	end
endmodule

// File: dv/ipr_src_model.sv
// Peripheral request source model feeding the request lines of the priority bank
`timescale 1ns/1ns
module ipr_src_model (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Pattern wanted by the bench, and requests as the peripherals drive them
	input  wire logic [21:0] want_i,
	output logic      [21:0] req_o
);
	// Requests move only just after an edge, like a peripheral's own flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_o <= 22'h00_0000;   // No source asks while in reset
		end else begin
			req_o <= want_i;        // Level held as long as the bench wants it
		end
	end
endmodule

// File: logic/ipr_pkg.sv
// Package for the interrupt priority register bank: map, field layout, reset values, sources
package ipr_pkg;

	// Bank geometry
	localparam int          NUM_REGS   = 6;                 // Priority registers in this bank
	localparam int          NUM_SRCS   = 22;                // Sources covered by the bank
	localparam int          REG_WIDTH  = 16;                // Implemented width of each register
	localparam int          LVL_WIDTH  = 3;                 // Width of one priority field

	// Byte offsets on the register bus, one aligned word each
	localparam logic [7:0]  OFS_PRIO_1 = 8'h00;             // priority_ctrl_1
	localparam logic [7:0]  OFS_PRIO_2 = 8'h04;             // priority_ctrl_2
	localparam logic [7:0]  OFS_PRIO_3 = 8'h08;             // priority_ctrl_3
	localparam logic [7:0]  OFS_PRIO_4 = 8'h0C;             // priority_ctrl_4
	localparam logic [7:0]  OFS_PRIO_5 = 8'h10;             // priority_ctrl_5
	localparam logic [7:0]  OFS_PRIO_6 = 8'h14;             // priority_ctrl_6

	// Field positions inside a register (low bit of each 3-bit field)
	localparam logic [3:0]  FLD_TOP    = 4'hC;              // Bits 14..12
	localparam logic [3:0]  FLD_UPPER  = 4'h8;              // Bits 10..8
	localparam logic [3:0]  FLD_LOWER  = 4'h4;              // Bits 6..4
	localparam logic [3:0]  FLD_BOTTOM = 4'h0;              // Bits 2..0

	// Implemented bits per register; everything else reads zero
	localparam logic [15:0] IMPL_MASK [0:5] = '{
		16'h7777, 16'h7777, 16'h0777, 16'h7777, 16'h7707, 16'h7777
	};

	// Reset pattern: every field at level four (100)
	localparam logic [15:0] RST_PATTERN = 16'h4444;

	// Level codes
	localparam logic [2:0]  LVL_OFF     = 3'h0;             // Source disabled
	localparam logic [2:0]  LVL_LOWEST  = 3'h1;             // Lowest enabled level
	localparam logic [2:0]  LVL_HIGHEST = 3'h7;             // Highest level

	// Source table: register index and field position for each source
	localparam logic [2:0]  SRC_REG [0:21] = '{
		3'h0, 3'h0, 3'h0, 3'h0,
		3'h1, 3'h1, 3'h1, 3'h1,
		3'h2, 3'h2, 3'h2,
		3'h3, 3'h3, 3'h3, 3'h3,
		3'h4, 3'h4, 3'h4,
		3'h5, 3'h5, 3'h5, 3'h5
	};
	localparam logic [3:0]  SRC_LSB [0:21] = '{
		FLD_TOP, FLD_UPPER, FLD_LOWER, FLD_BOTTOM,
		FLD_TOP, FLD_UPPER, FLD_LOWER, FLD_BOTTOM,
		FLD_UPPER, FLD_LOWER, FLD_BOTTOM,
		FLD_TOP, FLD_UPPER, FLD_LOWER, FLD_BOTTOM,
		FLD_TOP, FLD_UPPER, FLD_BOTTOM,
		FLD_TOP, FLD_UPPER, FLD_LOWER, FLD_BOTTOM
	};

endpackage

// File: logic/ipr_regs.sv
// Interrupt priority register bank with Wishbone slave and request gating
`timescale 1ns/1ns

// Notes on behaviour
// - Code 111 means level seven, the highest
// - Code 001 is level one; others map directly
// - Code 000 disables the source, never forwarded
// - Reset loads every field with level four
// - Unimplemented bits always read back zero
// - Fields at 14:12, 10:8, 6:4, 2:0
// - Register one: timer2, oc2, ic2, dma0
// - Register two: uart1 rx, spi1 event/error, timer3
// - Register three: dma1, adc1, uart1 tx only
// - Register four: change notify, comparator, i2c1 pair
// - Register five: ic8, ic7, external irq one
// - Register six: timer4, oc4, oc3, dma2
// - Implemented fields are read/write and steer arbitration
module ipr_regs #(
	parameter int ADDR_WIDTH = 8                             // Byte address width
) (
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	// Wishbone classic slave
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [ADDR_WIDTH-1:0]  adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic [31:0]            dat_i,
	output logic      [31:0]            dat_o,
	output logic                        ack_o,
	// Peripheral requests, one bit per source, same clock
	input  wire logic [21:0]            src_req_i,
	// Gated requests and highest pending level toward the core
	output logic      [21:0]            req_fwd_o,
	output logic      [2:0]             top_level_o,
	// Current level of each source
	output logic      [2:0]             timer_two_level_o,
	output logic      [2:0]             out_compare_two_level_o,
	output logic      [2:0]             in_capture_two_level_o,
	output logic      [2:0]             dma_ch_zero_level_o,
	output logic      [2:0]             uart_one_rx_level_o,
	output logic      [2:0]             spi_one_event_level_o,
	output logic      [2:0]             spi_one_error_level_o,
	output logic      [2:0]             timer_three_level_o,
	output logic      [2:0]             dma_ch_one_level_o,
	output logic      [2:0]             adc_one_done_level_o,
	output logic      [2:0]             uart_one_tx_level_o,
	output logic      [2:0]             change_notify_level_o,
	output logic      [2:0]             comparator_level_o,
	output logic      [2:0]             i2c_one_master_level_o,
	output logic      [2:0]             i2c_one_slave_level_o,
	output logic      [2:0]             in_capture_eight_level_o,
	output logic      [2:0]             in_capture_seven_level_o,
	output logic      [2:0]             ext_irq_one_level_o,
	output logic      [2:0]             timer_four_level_o,
	output logic      [2:0]             out_compare_four_level_o,
	output logic      [2:0]             out_compare_three_level_o,
	output logic      [2:0]             dma_ch_two_level_o
);

	// Register storage, one word per priority register
	logic [15:0] prio_bank [0:5];                            // Stored fields
	logic [2:0]  level     [0:21];                           // Per-source level view
	logic        bus_req;                                    // Live request on the bus
	logic        addr_hit;                                   // Address falls in the bank
	logic [2:0]  reg_idx;                                    // Decoded register index
	logic        wr_commit;                                  // Write lands at this edge
	logic [15:0] lane_mask;                                  // Byte lanes selected by sel_i
	logic [2:0]  next_top;                                   // Highest forwarded level

	// Bus decode; offsets are word aligned so bits 1:0 are ignored
	assign bus_req  = cyc_i && stb_i;
	assign reg_idx  = adr_i[4:2];
	assign addr_hit = (adr_i[ADDR_WIDTH-1:5] == '0) &&
	                  (reg_idx < 3'(ipr_pkg::NUM_REGS));
	assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};

	// A write takes effect on the edge where the master sees ack high,
	// so data is still held stable and nothing lands twice
	assign wr_commit = bus_req && we_i && ack_o && addr_hit;

	// Acknowledge: one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_req && !ack_o;
		end
	end

	// Read data is captured together with ack; unmapped words read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else if (bus_req && !ack_o && !we_i && addr_hit) begin
			// Stored bits are already masked, so unimplemented bits are zero
			dat_o <= {16'h0000, prio_bank[reg_idx]};
		end else begin
			dat_o <= 32'h0000_0000;
		end
	end

	// One storage process per register
	generate
		for (genvar r = 0; r < ipr_pkg::NUM_REGS; r++) begin : g_reg
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					// Every implemented field comes up at level four
					prio_bank[r] <= ipr_pkg::RST_PATTERN & ipr_pkg::IMPL_MASK[r];
				end else if (wr_commit && (reg_idx == 3'(r))) begin
					// Merge selected lanes, then drop unimplemented bits
					prio_bank[r] <= ((prio_bank[r] & ~lane_mask) | (dat_i[15:0] & lane_mask))
					                & ipr_pkg::IMPL_MASK[r];
				end
			end
		end
	endgenerate

	// Per-source field extraction and request gating
	generate
		for (genvar s = 0; s < ipr_pkg::NUM_SRCS; s++) begin : g_src
			// Field slice by source table position
			assign level[s] = prio_bank[ipr_pkg::SRC_REG[s]][ipr_pkg::SRC_LSB[s] +: 3];

			// A zero level blocks the request outright
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					req_fwd_o[s] <= 1'b0;
				end else begin
					req_fwd_o[s] <= src_req_i[s] && (level[s] != ipr_pkg::LVL_OFF);
				end
			end
		end
	endgenerate

	// Highest level among gated requests; code value is the level itself
	always_comb begin
		next_top = ipr_pkg::LVL_OFF;
		for (int s = 0; s < ipr_pkg::NUM_SRCS; s++) begin
			// 111 outranks all, 001 is the lowest that still counts
			if (src_req_i[s] && (level[s] > next_top)) begin
				next_top = level[s];
			end
		end
	end

	// Pending level register toward the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			top_level_o <= ipr_pkg::LVL_OFF;
		end else begin
			top_level_o <= next_top;
		end
	end

	// Level outputs come straight from the stored fields
	assign timer_two_level_o         = level[0];
	assign out_compare_two_level_o   = level[1];
	assign in_capture_two_level_o    = level[2];
	assign dma_ch_zero_level_o       = level[3];
	assign uart_one_rx_level_o       = level[4];
	assign spi_one_event_level_o     = level[5];
	assign spi_one_error_level_o     = level[6];
	assign timer_three_level_o       = level[7];
	assign dma_ch_one_level_o        = level[8];
	assign adc_one_done_level_o      = level[9];
	assign uart_one_tx_level_o       = level[10];
	assign change_notify_level_o     = level[11];
	assign comparator_level_o        = level[12];
	assign i2c_one_master_level_o    = level[13];
	assign i2c_one_slave_level_o     = level[14];
	assign in_capture_eight_level_o  = level[15];
	assign in_capture_seven_level_o  = level[16];
	assign ext_irq_one_level_o       = level[17];
	assign timer_four_level_o        = level[18];
	assign out_compare_four_level_o  = level[19];
	assign out_compare_three_level_o = level[20];
	assign dma_ch_two_level_o        = level[21];

	// Checks; helper flags for the first cycle after reset release
	logic rst_d;                                             // Reset seen last cycle
	always_ff @(posedge clk_i) begin
		rst_d <= rst_i;
	end

	// Disabled sources never reach the core
	property p_off_blocks;
		@(posedge clk_i) disable iff (rst_i)
		(dma_ch_zero_level_o == 3'h0) |=> !req_fwd_o[3] || ($past(dma_ch_zero_level_o) != 3'h0);
	endproperty
	a_off_blocks: assert property (p_off_blocks) else $error("disabled source forwarded");

	// Enabled requests are forwarded one cycle later
	property p_fwd;
		@(posedge clk_i) disable iff (rst_i)
		(src_req_i[0] && timer_two_level_o != 3'h0) |=> req_fwd_o[0];
	endproperty
	a_fwd: assert property (p_fwd) else $error("enabled request not forwarded");

	// After reset every field reads level four
	property p_reset_val;
		@(posedge clk_i)
		(rst_d && !rst_i) |-> (timer_two_level_o == 3'h4) && (ext_irq_one_level_o == 3'h4)
		                      && (dma_ch_two_level_o == 3'h4) && (dma_ch_one_level_o == 3'h4);
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("reset level not four");

	// Unimplemented bits of register five never hold a one
	property p_unimpl_zero;
		@(posedge clk_i) disable iff (rst_i)
		(prio_bank[4] & ~16'h7707) == 16'h0000 && (prio_bank[2] & 16'hF888) == 16'h0000;
	endproperty
	a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

	// Read data never shows bits above 15
	property p_read_upper;
		@(posedge clk_i) disable iff (rst_i)
		ack_o |-> (dat_o[31:16] == 16'h0000) && (dat_o[15] == 1'b0) && (dat_o[3] == 1'b0);
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("reserved read bit set");

	// Ack answers a request in one cycle and lasts one cycle
	property p_ack_pulse;
		@(posedge clk_i) disable iff (rst_i)
		(cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack timing wrong");

	// An upper-lane write to register one shows on its top field next cycle
	property p_write_top;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h0 && sel_i[1]) |=> timer_two_level_o == $past(dat_i[14:12]);
	endproperty
	a_write_top: assert property (p_write_top) else $error("write not stored");

	// Top level equals seven whenever a seven-level request was seen
	property p_top_seven;
		@(posedge clk_i) disable iff (rst_i)
		(src_req_i[20] && out_compare_three_level_o == 3'h7) |=> top_level_o == 3'h7;
	endproperty
	a_top_seven: assert property (p_top_seven) else $error("level seven not highest");

	// A lone level-one request gives top level one
	property p_top_one;
		@(posedge clk_i) disable iff (rst_i)
		(src_req_i == 22'h00_0001 && timer_two_level_o == 3'h1) |=> top_level_o == 3'h1;
	endproperty
	a_top_one: assert property (p_top_one) else $error("level one mapped wrong");

	// Output levels never change without a committed write
	property p_hold;
		@(posedge clk_i) disable iff (rst_i)
		!wr_commit |=> $stable(spi_one_error_level_o) && $stable(in_capture_seven_level_o);
	endproperty
	a_hold: assert property (p_hold) else $error("level changed without write");

	// Data lines stay at zero whenever no acknowledge is shown
	property p_idle_zero;
		@(posedge clk_i) disable iff (rst_i)
		!ack_o |-> (dat_o == 32'h0000_0000);
	endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("read data outside ack");

	// Outputs come out of reset quiet: no ack, no data, nothing forwarded
	property p_reset_out;
		@(posedge clk_i)
		(rst_d && !rst_i) |-> !ack_o && (dat_o == 32'h0000_0000) && (req_fwd_o == 22'h00_0000);
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs busy after reset");

	// A withdrawn request is no longer forwarded one cycle later
	property p_fwd_drop;
		@(posedge clk_i) disable iff (rst_i)
		!src_req_i[21] |=> !req_fwd_o[21];
	endproperty
	a_fwd_drop: assert property (p_fwd_drop) else $error("withdrawn request forwarded");

	// No request at all leaves no pending level and nothing forwarded
	property p_top_idle;
		@(posedge clk_i) disable iff (rst_i)
		(src_req_i == 22'h00_0000) |=> (top_level_o == 3'h0) && (req_fwd_o == 22'h00_0000);
	endproperty
	a_top_idle: assert property (p_top_idle) else $error("pending level without request");

	// Requests from disabled sources only must not raise the pending level
	property p_top_off;
		@(posedge clk_i) disable iff (rst_i)
		(src_req_i == 22'h00_000C) && (in_capture_two_level_o == 3'h0) &&
		(dma_ch_zero_level_o == 3'h0) |=> (top_level_o == 3'h0);
	endproperty
	a_top_off: assert property (p_top_off) else $error("disabled source raised level");

	// A write to register two lands in its top field
	property p_write_reg2;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h1 && sel_i[1]) |=> uart_one_rx_level_o == $past(dat_i[14:12]);
	endproperty
	a_write_reg2: assert property (p_write_reg2) else $error("register two write lost");

	// Register three stores its upper field and keeps bits 15 to 11 clear
	property p_write_reg3;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h2 && sel_i[1]) |=>
		(dma_ch_one_level_o == $past(dat_i[10:8])) && (prio_bank[2][15:11] == 5'h00);
	endproperty
	a_write_reg3: assert property (p_write_reg3) else $error("register three write wrong");

	// Register four stores its bottom field
	property p_write_reg4;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h3 && sel_i[0]) |=> i2c_one_slave_level_o == $past(dat_i[2:0]);
	endproperty
	a_write_reg4: assert property (p_write_reg4) else $error("register four write lost");

	// Register five stores its bottom field and keeps bits 7 to 3 clear
	property p_write_reg5;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h4 && sel_i[0]) |=>
		(ext_irq_one_level_o == $past(dat_i[2:0])) && (prio_bank[4][7:3] == 5'h00);
	endproperty
	a_write_reg5: assert property (p_write_reg5) else $error("register five write wrong");

	// Register six stores its bottom field
	property p_write_reg6;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h5 && sel_i[0]) |=> dma_ch_two_level_o == $past(dat_i[2:0]);
	endproperty
	a_write_reg6: assert property (p_write_reg6) else $error("register six write lost");

	// An unselected upper lane keeps its fields; only chosen lanes change
	property p_lane_keep;
		@(posedge clk_i) disable iff (rst_i)
		(wr_commit && reg_idx == 3'h0 && !sel_i[1]) |=>
		$stable(timer_two_level_o) && $stable(out_compare_two_level_o);
	endproperty
	a_lane_keep: assert property (p_lane_keep) else $error("unselected lane changed");

	// Register one reads back its four fields at their bit positions
	property p_read_reg1;
		@(posedge clk_i) disable iff (rst_i)
		(bus_req && !ack_o && !we_i && addr_hit && reg_idx == 3'h0) |=>
		dat_o == {16'h0000, 1'b0, $past(timer_two_level_o), 1'b0, $past(out_compare_two_level_o),
		          1'b0, $past(in_capture_two_level_o), 1'b0, $past(dma_ch_zero_level_o)};
	endproperty
	a_read_reg1: assert property (p_read_reg1) else $error("register one read wrong");

endmodule
